// ### rtl/gcpe_defines.vh
// Constants of the pin control command engine: register offsets,
// reset values, command codes and response framing.
// Assumes inclusion by bare name from files under rtl/.
`ifndef GCPE_DEFINES_VH
`define GCPE_DEFINES_VH

// ----------------------------------------------------------------
// Pin count and bitmap width
// ----------------------------------------------------------------
`define GCPE_NPIN        11
`define GCPE_MAPW        32

// ----------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------
`define GCPE_Q_FUNC      8'h10
`define GCPE_Q_DIR       8'h11
`define GCPE_Q_LVL       8'h12
`define GCPE_Q_STATE     8'h13
`define GCPE_S_DIR       8'h19
`define GCPE_S_LVL       8'h1A
`define GCPE_S_STATE     8'h1B
`define GCPE_ERR_BYTE    8'hFF

// ----------------------------------------------------------------
// Framing
// ----------------------------------------------------------------
`define GCPE_CMD_LAST    4'h8
`define GCPE_RSP_LEN_OK  3'h5
`define GCPE_RSP_LEN_ERR 3'h1

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define GCPE_OFS_CTRL    12'h000
`define GCPE_OFS_CFG_FN  12'h004
`define GCPE_OFS_CFG_DIR 12'h008
`define GCPE_OFS_CFG_LVL 12'h00C
`define GCPE_OFS_DIR     12'h010
`define GCPE_OFS_LVL     12'h014
`define GCPE_OFS_STATE   12'h018
`define GCPE_OFS_STATUS  12'h01C

// ----------------------------------------------------------------
// Control fields and reset values
// ----------------------------------------------------------------
`define GCPE_CTRL_EN     0
`define GCPE_CTRL_LOAD   1
`define GCPE_RST_FN      11'h7FF
`define GCPE_RST_DIR     11'h000
`define GCPE_RST_LVL     11'h7FF
`define GCPE_RST_STATE   11'h000

`endif

// ### rtl/gcpe_pin_bank.v
// Pin bank: physical drive and readback for the controllable pins.
// Assumes pin_in is synchronous to pclk; the pad ring combines
// pin_out and pin_oe into the wire level.
`timescale 1ns/1ps
`default_nettype none
`include "gcpe_defines.vh"

module gcpe_pin_bank (
    // Clock and reset
    input  wire                 pclk,
    input  wire                 presetn,
    // Live settings
    input  wire [10:0]          func,
    input  wire [10:0]          dir,
    input  wire [10:0]          lvl,
    input  wire [10:0]          state,
    // Pads
    input  wire [10:0]          pin_in,
    output reg  [10:0]          pin_out,
    output reg  [10:0]          pin_oe,
    // Logical readback
    output wire [10:0]          state_rd
);

    reg [10:0] in_ff;

    genvar gi;
    generate
        for (gi = 0; gi < `GCPE_NPIN; gi = gi + 1) begin : g_pin
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    pin_out[gi] <= 1'b0;
                    pin_oe[gi]  <= 1'b0;
                    in_ff[gi]   <= 1'b0;
                end else begin
                    // Active low pins drive the inverted state
                    pin_out[gi] <= state[gi] ^ lvl[gi];
                    // Inputs and dedicated pins stay undriven
                    pin_oe[gi]  <= dir[gi] & func[gi];
                    in_ff[gi]   <= pin_in[gi];
                end
            end
            // Inputs report the pad level seen through polarity
            assign state_rd[gi] = dir[gi] ? state[gi] :
                                  (in_ff[gi] ^ lvl[gi]);
        end
    endgenerate

endmodule // gcpe_pin_bank
`default_nettype wire

// ### rtl/gcpe_top.v
// Pin control command engine: takes nine-byte commands from a
// network byte stream, answers with echo plus bitmap, drives pins.
// Assumes the network stack delivers payload bytes in order, marks
// datagram ends for UDP, and that software uses APB for settings.
//
// Functional notes
// - Eleven pins are controlled; bitmaps always carry 32 positions.
// - Reset default: general purpose, input, active low per pin.
// - Stored direction and level apply only on a load write to the control register.
// - Directions, levels and states are set and read over the port.
// - Commands may arrive over TCP streams or UDP datagrams.
// - A command is one code byte then two four-byte parameters.
// - Parameters are little-endian bitmaps, pin 0 in bit 0.
// - Dedicated pins read as zero and are ignored when set.
// - A valid command answers five bytes: code, then bitmap.
// - An unknown code answers one byte 0xFF and changes only the last code in status.
// - Valid codes: four queries and three set commands.
// - Pin function changes only through the configuration port.
// - Set values are volatile and revert on reset or on a reload outside the execute cycle.
// - Function query ignores parameters, 1 means general purpose.
// - Direction query: 1 output, 0 input.
// - Level query: 1 active low, 0 active high.
// - State query: 1 active, 0 inactive.
// - Set commands change only pins whose mask bit is 1.
// - Set state makes masked pins active for 1, answers new states for outputs, pad states for inputs.
// - Set level makes masked pins active low for 1.
`timescale 1ns/1ps
`default_nettype none
`include "gcpe_defines.vh"

module gcpe_top (
    // Clock and reset
    input  wire                 pclk,
    input  wire                 presetn,
    // APB slave
    input  wire                 psel,
    input  wire                 penable,
    input  wire                 pwrite,
    input  wire [11:0]          paddr,
    input  wire [31:0]          pwdata,
    output reg  [31:0]          prdata,
    output reg                  pready,
    output reg                  pslverr,
    // Command byte stream from the network stack
    input  wire [7:0]           cmd_data,
    input  wire                 cmd_valid,
    input  wire                 cmd_udp,
    input  wire                 cmd_end,
    output reg                  cmd_ready,
    // Response byte stream to the network stack
    output reg  [7:0]           rsp_data,
    output reg                  rsp_valid,
    output reg                  rsp_last,
    input  wire                 rsp_ready,
    // Pads
    input  wire [10:0]          pin_in,
    output wire [10:0]          pin_out,
    output wire [10:0]          pin_oe
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    localparam S_RX  = 2'd0;
    localparam S_EXE = 2'd1;
    localparam S_TX  = 2'd2;

    reg  [1:0]  st_ff;
    reg  [1:0]  nxt_st;
    reg  [3:0]  rx_cnt_ff;
    reg  [3:0]  nxt_rx_cnt;
    reg  [7:0]  op_ff;
    reg  [7:0]  nxt_op;
    reg  [31:0] p1_ff;
    reg  [31:0] nxt_p1;
    reg  [31:0] p2_ff;
    reg  [31:0] nxt_p2;
    reg  [39:0] rsp_buf_ff;
    reg  [39:0] nxt_rsp_buf;
    reg  [2:0]  tx_left_ff;
    reg  [2:0]  nxt_tx_left;
    reg  [10:0] dir_ff;
    reg  [10:0] nxt_dir;
    reg  [10:0] lvl_ff;
    reg  [10:0] nxt_lvl;
    reg  [10:0] state_ff;
    reg  [10:0] nxt_state;
    reg  [10:0] cfg_fn_ff;
    reg  [10:0] cfg_dir_ff;
    reg  [10:0] cfg_lvl_ff;
    reg         en_ff;
    reg  [7:0]  last_op_ff;
    reg  [7:0]  nxt_last_op;
    reg  [10:0] word;
    reg         bad;
    reg  [31:0] rd_mux;
    reg         rd_err;

    wire [10:0] gp = cfg_fn_ff;
    wire [10:0] msk = p1_ff[10:0] & gp;
    wire [10:0] val = p2_ff[10:0];
    wire [10:0] state_rd;
    wire [4:0]  byte_sel = {rx_cnt_ff[1:0] - 2'd1, 3'b000};
    wire        wr_acc = psel & penable & pready & pwrite;
    wire        load = wr_acc && (paddr == `GCPE_OFS_CTRL) &&
                       pwdata[`GCPE_CTRL_LOAD];

    // ------------------------------------------------------------
    // Pin bank
    // ------------------------------------------------------------
    gcpe_pin_bank u_bank (
        .pclk     (pclk),
        .presetn  (presetn),
        .func     (cfg_fn_ff),
        .dir      (dir_ff),
        .lvl      (lvl_ff),
        .state    (state_ff),
        .pin_in   (pin_in),
        .pin_out  (pin_out),
        .pin_oe   (pin_oe),
        .state_rd (state_rd)
    );

    // ------------------------------------------------------------
    // Command engine
    // ------------------------------------------------------------
    always @* begin
        nxt_st      = st_ff;
        nxt_rx_cnt  = rx_cnt_ff;
        nxt_op      = op_ff;
        nxt_p1      = p1_ff;
        nxt_p2      = p2_ff;
        nxt_rsp_buf = rsp_buf_ff;
        nxt_tx_left = tx_left_ff;
        nxt_dir     = dir_ff;
        nxt_lvl     = lvl_ff;
        nxt_state   = state_ff;
        nxt_last_op = last_op_ff;
        word        = 11'h000;
        bad         = 1'b0;
        case (st_ff)
            S_RX: begin
                // Bytes arriving while the port is off are swallowed
                if (cmd_valid && cmd_ready && en_ff) begin
                    if (rx_cnt_ff == 4'h0)
                        nxt_op = cmd_data;
                    else if (rx_cnt_ff < 4'h5)
                        nxt_p1[byte_sel +: 8] = cmd_data;
                    else
                        nxt_p2[byte_sel +: 8] = cmd_data;
                    if (rx_cnt_ff == `GCPE_CMD_LAST) begin
                        nxt_rx_cnt = 4'h0;
                        nxt_st     = S_EXE;
                    end else if (cmd_udp && cmd_end) begin
                        // Short datagram: never spans two packets
                        nxt_rx_cnt = 4'h0;
                    end else begin
                        nxt_rx_cnt = rx_cnt_ff + 4'h1;
                    end
                end
            end
            S_EXE: begin
                nxt_last_op = op_ff;
                case (op_ff)
                    `GCPE_Q_FUNC:  word = gp;
                    `GCPE_Q_DIR:   word = dir_ff & gp;
                    `GCPE_Q_LVL:   word = lvl_ff & gp;
                    `GCPE_Q_STATE: word = state_rd & gp;
                    `GCPE_S_DIR: begin
                        nxt_dir = (dir_ff & ~msk) | (val & msk);
                        word    = nxt_dir & gp;
                    end
                    `GCPE_S_LVL: begin
                        nxt_lvl = (lvl_ff & ~msk) | (val & msk);
                        word    = nxt_lvl & gp;
                    end
                    `GCPE_S_STATE: begin
                        nxt_state = (state_ff & ~msk) | (val & msk);
                        word = ((nxt_state & dir_ff) |
                                (state_rd & ~dir_ff)) & gp;
                    end
                    default: bad = 1'b1;
                endcase
                if (bad) begin
                    nxt_rsp_buf = {32'h0000_0000, `GCPE_ERR_BYTE};
                    nxt_tx_left = `GCPE_RSP_LEN_ERR;
                end else begin
                    // Positions above the real pins read as zero
                    nxt_rsp_buf = {21'h00_0000, word,
                                   op_ff};
                    nxt_tx_left = `GCPE_RSP_LEN_OK;
                end
                nxt_st = S_TX;
            end
            S_TX: begin
                if (rsp_ready) begin
                    nxt_rsp_buf = {8'h00, rsp_buf_ff[39:8]};
                    nxt_tx_left = tx_left_ff - 3'h1;
                    if (tx_left_ff == 3'h1)
                        nxt_st = S_RX;
                end
            end
            default: nxt_st = S_RX;
        endcase
        // A reload while no command is executing restores stored direction and level and clears states
        if (load && st_ff != S_EXE) begin
            nxt_dir   = cfg_dir_ff;
            nxt_lvl   = cfg_lvl_ff;
            nxt_state = `GCPE_RST_STATE;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff      <= S_RX;
            rx_cnt_ff  <= 4'h0;
            op_ff      <= 8'h00;
            p1_ff      <= 32'h0000_0000;
            p2_ff      <= 32'h0000_0000;
            rsp_buf_ff <= 40'h00_0000_0000;
            tx_left_ff <= 3'h0;
            dir_ff     <= `GCPE_RST_DIR;
            lvl_ff     <= `GCPE_RST_LVL;
            state_ff   <= `GCPE_RST_STATE;
            last_op_ff <= 8'h00;
            cmd_ready  <= 1'b0;
            rsp_valid  <= 1'b0;
            rsp_last   <= 1'b0;
            rsp_data   <= 8'h00;
        end else begin
            st_ff      <= nxt_st;
            rx_cnt_ff  <= nxt_rx_cnt;
            op_ff      <= nxt_op;
            p1_ff      <= nxt_p1;
            p2_ff      <= nxt_p2;
            rsp_buf_ff <= nxt_rsp_buf;
            tx_left_ff <= nxt_tx_left;
            dir_ff     <= nxt_dir;
            lvl_ff     <= nxt_lvl;
            state_ff   <= nxt_state;
            last_op_ff <= nxt_last_op;
            // Ready drops in the cycle after the ninth byte
            cmd_ready  <= (nxt_st == S_RX);
            rsp_valid  <= (nxt_st == S_TX);
            rsp_last   <= (nxt_st == S_TX) && (nxt_tx_left == 3'h1);
            rsp_data   <= nxt_rsp_buf[7:0];
        end
    end

    // ------------------------------------------------------------
    // APB register file
    // ------------------------------------------------------------
    always @* begin
        rd_mux = 32'h0000_0000;
        rd_err = 1'b0;
        case (paddr)
            `GCPE_OFS_CTRL:    rd_mux = {31'h0000_0000, en_ff};
            `GCPE_OFS_CFG_FN:  rd_mux = {21'h00_0000, cfg_fn_ff};
            `GCPE_OFS_CFG_DIR: rd_mux = {21'h00_0000, cfg_dir_ff};
            `GCPE_OFS_CFG_LVL: rd_mux = {21'h00_0000, cfg_lvl_ff};
            `GCPE_OFS_DIR:     rd_mux = {21'h00_0000, dir_ff};
            `GCPE_OFS_LVL:     rd_mux = {21'h00_0000, lvl_ff};
            `GCPE_OFS_STATE:   rd_mux = {21'h00_0000, state_rd};
            `GCPE_OFS_STATUS:  rd_mux = {16'h0000, last_op_ff,
                                         6'h00, st_ff};
            default:           rd_err = 1'b1;
        endcase
    end

    // One wait-free access: pready rises in the access phase
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else if (psel && !penable) begin
            prdata  <= pwrite ? 32'h0000_0000 : rd_mux;
            pready  <= 1'b1;
            pslverr <= rd_err;
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // Stored configuration; function is writable only from here
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_ff      <= 1'b1;
            cfg_fn_ff  <= `GCPE_RST_FN;
            cfg_dir_ff <= `GCPE_RST_DIR;
            cfg_lvl_ff <= `GCPE_RST_LVL;
        end else if (wr_acc) begin
            case (paddr)
                `GCPE_OFS_CTRL:    en_ff      <= pwdata[`GCPE_CTRL_EN];
                `GCPE_OFS_CFG_FN:  cfg_fn_ff  <= pwdata[10:0];
                `GCPE_OFS_CFG_DIR: cfg_dir_ff <= pwdata[10:0];
                `GCPE_OFS_CFG_LVL: cfg_lvl_ff <= pwdata[10:0];
                default:           en_ff      <= en_ff;
            endcase
        end
    end

endmodule // gcpe_top
`default_nettype wire

// ### verif/gcpe_checker_assertions.sv
// Checker for the pin control command engine: stream framing and timing.
// Assumes it is bound to gcpe_top and sees only its ports.
`timescale 1ns/1ps
`default_nettype none

module gcpe_checker (
    // Clock and reset
    input wire logic       pclk,
    input wire logic       presetn,
    // APB handshake and control writes
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    // Command and response streams
    input wire logic [7:0] cmd_data,
    input wire logic       cmd_valid,
    input wire logic       cmd_udp,
    input wire logic       cmd_end,
    input wire logic       cmd_ready,
    input wire logic [7:0] rsp_data,
    input wire logic       rsp_valid,
    input wire logic       rsp_last,
    input wire logic       rsp_ready
);
    logic [3:0] cnt_ff;
    logic [7:0] code_ff;
    logic [2:0] rcnt_ff;
    logic       ok;
    logic       wrap;
    logic       en_ff;
    logic       take;

    // ------------------------------------------------------------
    // Byte positions, judged from the wire alone
    // ------------------------------------------------------------
    // Bytes taken while the port is off are dropped, so not counted
    assign take = cmd_valid && cmd_ready && en_ff;
    assign wrap = (cnt_ff == 4'h8) || (cmd_udp && cmd_end);
    assign ok   = code_ff inside {8'h10, 8'h11, 8'h12, 8'h13,
                                  8'h19, 8'h1A, 8'h1B};

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_ff  <= 4'h0;
            code_ff <= 8'h00;
            rcnt_ff <= 3'h0;
            en_ff   <= 1'b1;
        end else begin
            if (psel && penable && pready && pwrite && paddr == 12'h000)
                en_ff <= pwdata[0];
            if (take) begin
                if (cnt_ff == 4'h0) code_ff <= cmd_data;
                cnt_ff <= wrap ? 4'h0 : cnt_ff + 4'h1;
            end
            if (rsp_valid && rsp_ready)
                rcnt_ff <= rsp_last ? 3'h0 : rcnt_ff + 3'h1;
        end
    end

    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_ninth_stops: assert property (
        take && cnt_ff == 4'h8 |=> !cmd_ready)
        else $error("engine kept taking after nine bytes");
    a_part_drop: assert property (
        cmd_valid && cmd_ready && cmd_udp && cmd_end && cnt_ff < 4'h8
        |=> cmd_ready && !rsp_valid)
        else $error("partial datagram was not discarded");
    a_rsp_soon: assert property (
        $fell(cmd_ready) |-> ##[1:3] rsp_valid)
        else $error("no response after a full command");
    a_rsp_hold: assert property (
        rsp_valid && !rsp_ready
        |=> rsp_valid && $stable(rsp_data) && $stable(rsp_last))
        else $error("response byte changed before it was taken");
    a_echo_code: assert property (
        rsp_valid && rcnt_ff == 3'h0 && ok
        |-> rsp_data == code_ff && !rsp_last) else $error("bad echo byte");
    a_bad_code: assert property (
        rsp_valid && !ok
        |-> rsp_data == 8'hFF && rsp_last) else $error("bad error reply");
    a_five_bytes: assert property (
        rsp_valid && rsp_last && ok
        |-> rcnt_ff == 3'h4) else $error("valid reply not five bytes");
    a_upper_zero: assert property (
        rsp_valid && rcnt_ff >= 3'h2
        |-> rsp_data[7:3] == 5'h00 && (rcnt_ff == 3'h2 || rsp_data == 8'h00))
        else $error("bitmap bits above pin ten set");
    a_done_free: assert property (
        rsp_valid && rsp_ready && rsp_last
        |=> !rsp_valid && cmd_ready) else $error("not ready after reply");
    a_apb_ready: assert property (
        psel && !penable |=> pready)
        else $error("no ready in access phase");
    a_off_quiet: assert property (
        cmd_valid && cmd_ready && !en_ff |=> !rsp_valid)
        else $error("disabled port produced a reply");

    c_err_reply: cover property (rsp_valid && rsp_ready && rsp_last && !ok);
    c_ok_reply: cover property (rsp_valid && rsp_ready && rsp_last && ok);
    c_part_udp: cover property (cmd_valid && cmd_ready && cmd_udp && cmd_end
        && cnt_ff < 4'h8);
    c_port_off: cover property (cmd_valid && cmd_ready && !en_ff);
endmodule // gcpe_checker
`default_nettype wire

// ### verif/gcpe_host_model.sv
// Remote host model: sends nine-byte commands and collects replies.
// Assumes one clock shared with the engine; tasks are called by the bench.
`timescale 1ns/1ps
`default_nettype none

module gcpe_host_model (
    // Clock
    input  wire logic       pclk,
    // Command stream
    output var  logic [7:0] cmd_data,
    output var  logic       cmd_valid,
    output var  logic       cmd_udp,
    output var  logic       cmd_end,
    input  wire logic       cmd_ready,
    // Response stream
    input  wire logic [7:0] rsp_data,
    input  wire logic       rsp_valid,
    input  wire logic       rsp_last,
    output var  logic       rsp_ready
);
    initial begin
        cmd_data  = 8'h00;
        cmd_valid = 1'b0;
        cmd_udp   = 1'b0;
        cmd_end   = 1'b0;
        rsp_ready = 1'b0;
    end

    // Fewer than nine bytes with udp set models a broken datagram
    task automatic xfer(input logic [7:0] c, input logic [31:0] m, v,
                        input int nb, input bit udp,
                        output logic [7:0] r[$], output bit to);
        logic [71:0] w;
        int          k;
        w  = {v, m, c};
        to = 0;
        r  = {};
        for (int i = 0; i < nb; i++) begin
            cmd_data  <= w[8*i+:8];
            cmd_valid <= 1'b1;
            cmd_udp   <= udp;
            cmd_end   <= udp && (i == nb - 1);
            k = 0;
            do begin
                @(posedge pclk);
                k++;
            end while (cmd_ready !== 1'b1 && k < 50);
            if (k >= 50) to = 1;
        end
        cmd_valid <= 1'b0;
        cmd_end   <= 1'b0;
        // Idle data is scrambled so a stale byte never looks valid
        cmd_data  <= ~w[8*(nb-1)+:8];
        // Whole reply is taken before the next command goes out
        for (k = 0; k < 60; k++) begin
            @(posedge pclk);
            if (rsp_valid === 1'b1 && rsp_ready) begin
                r.push_back(rsp_data);
                if (rsp_last) break;
            end
            // The final step is left to the release below
            if (k < 59) rsp_ready <= ($urandom % 3) != 0;
        end
        if (nb == 9 && k >= 60) to = 1;
        rsp_ready <= 1'b0;
    endtask
endmodule // gcpe_host_model
`default_nettype wire

// ### verif/gcpe_top_tb.sv
// Bench for the pin control command engine with a reference model.
// Assumes the design, host model and checker are compiled beforehand.
`timescale 1ns/1ps
`default_nettype none
`include "gcpe_defines.vh"

module gcpe_top_tb;
    logic        pclk = 0, presetn = 0;
    logic        psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata;
    logic        pready, pslverr, cmd_valid, cmd_udp, cmd_end, cmd_ready;
    logic [7:0]  cmd_data, rsp_data;
    logic        rsp_valid, rsp_last, rsp_ready;
    logic [10:0] pin_in = 11'h000, pin_out, pin_oe;
    logic [10:0] fn, dr, lv, st;
    int          err_total = 0, total_checks = 0;
    // Last slot is replaced by a random invalid code
    logic [7:0]  codes [8] = '{`GCPE_Q_FUNC, `GCPE_Q_DIR, `GCPE_Q_LVL,
        `GCPE_Q_STATE, `GCPE_S_DIR, `GCPE_S_LVL, `GCPE_S_STATE, 8'h10};

    gcpe_top i_gcpe_top (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cmd_data(cmd_data), .cmd_valid(cmd_valid), .cmd_udp(cmd_udp),
        .cmd_end(cmd_end), .cmd_ready(cmd_ready), .rsp_data(rsp_data),
        .rsp_valid(rsp_valid), .rsp_last(rsp_last), .rsp_ready(rsp_ready),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));
    gcpe_host_model host (.pclk(pclk), .cmd_data(cmd_data),
        .cmd_valid(cmd_valid), .cmd_udp(cmd_udp), .cmd_end(cmd_end),
        .cmd_ready(cmd_ready), .rsp_data(rsp_data), .rsp_valid(rsp_valid),
        .rsp_last(rsp_last), .rsp_ready(rsp_ready));

    always #20 pclk = ~pclk;

    // ------------------------------------------------------------
    // Checking and bus tasks
    // ------------------------------------------------------------
    task automatic chk(string n, logic [39:0] e, logic [39:0] g);
        total_checks++;
        if (g !== e) begin
            err_total++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask

    task automatic conclude();
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic apb(bit wr, logic [11:0] a, logic [31:0] d,
                       output logic [31:0] q, output logic e);
        int k;
        k = 0;
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k >= 20) begin
            err_total++;
            conclude();
        end
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic do_reset();
        presetn <= 1'b0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        fn = 11'h7FF;
        dr = 11'h000;
        lv = 11'h7FF;
        st = 11'h000;
    endtask

    // Inputs report the pad seen through their polarity
    function automatic logic [10:0] lstate();
        return (st & dr) | ((pin_in ^ lv) & ~dr);
    endfunction

    task automatic cmd(logic [7:0] c, logic [31:0] m, v);
        logic [7:0]  r[$];
        logic [39:0] e, g;
        logic [10:0] mm, b;
        bit          to;
        int          n;
        host.xfer(c, m, v, 9, $urandom % 2, r, to);
        if (to) begin
            err_total++;
            conclude();
        end
        mm = m[10:0] & fn;
        case (c)
            8'h19: dr = (dr & ~mm) | (v[10:0] & mm);
            8'h1A: lv = (lv & ~mm) | (v[10:0] & mm);
            8'h1B: st = (st & ~mm) | (v[10:0] & mm);
            default: ;
        endcase
        case (c)
            8'h10: b = fn;
            8'h11, 8'h19: b = dr & fn;
            8'h12, 8'h1A: b = lv & fn;
            8'h13, 8'h1B: b = lstate() & fn;
            default: b = 11'h000;
        endcase
        n = (c inside {codes}) ? 5 : 1;
        e = (n == 5) ? {21'h00_0000, b, c} : 40'h00_0000_00FF;
        g = 40'h00_0000_0000;
        foreach (r[i]) g[8*i+:8] = r[i];
        chk("rsp_len", n, r.size());
        chk("rsp", e, g);
        chk("pin_oe", dr & fn, pin_oe);
        chk("pin_out", (st ^ lv) & dr & fn, pin_out & pin_oe);
    endtask

    task automatic run(int n);
        logic [7:0] c;
        for (int i = 0; i < n; i++) begin
            pin_in <= $urandom;
            @(posedge pclk);
            c = codes[i % 8];
            while (i % 8 == 7 && c inside {codes}) c = $urandom;
            cmd(c, $urandom, $urandom);
        end
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        logic [31:0] q;
        logic        e;
        logic [7:0]  r[$];
        bit          to;
        q = $urandom(32'h79ba_e9b6);
        do_reset();
        apb(0, 12'h010, 32'h0000_0000, q, e);
        chk("dir_reg", dr, q);
        apb(1, 12'h014, 32'h0000_0000, q, e);
        apb(0, 12'h014, 32'h0000_0000, q, e);
        chk("lvl_reg", lv, q);
        apb(0, 12'h020, 32'h0000_0000, q, e);
        chk("unmapped", 40'h01_0000_0000, {e, q});
        run(16);
        host.xfer(8'h19, 32'h0000_07FF, 32'h0000_07FF, 5, 1, r, to);
        chk("udp_part", 0, r.size() + to);
        cmd(8'h11, 32'h0000_0000, 32'h0000_0000);
        // Port off: a full command is swallowed with no reply
        apb(1, 12'h000, 32'h0000_0000, q, e);
        host.xfer(8'h19, 32'h0000_07FF, 32'h0000_07FF, 9, 0, r, to);
        apb(1, 12'h000, 32'h0000_0001, q, e);
        chk("port_off", 0, r.size());
        cmd(8'h11, 32'h0000_0000, 32'h0000_0000);
        do_reset();
        cmd(8'h12, $urandom, $urandom);
        apb(1, 12'h004, 32'h0000_0203, q, e);
        apb(1, 12'h008, 32'h0000_0601, q, e);
        apb(1, 12'h00C, 32'h0000_0402, q, e);
        apb(1, 12'h000, 32'h0000_0003, q, e);
        fn = 11'h203;
        dr = 11'h601;
        lv = 11'h402;
        st = 11'h000;
        run(24);
        apb(0, 12'h018, 32'h0000_0000, q, e);
        chk("state_reg", lstate(), q);
        conclude();
    end
endmodule // gcpe_top_tb

bind gcpe_top gcpe_checker i_gcpe_checker (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .cmd_data(cmd_data),
    .cmd_valid(cmd_valid), .cmd_udp(cmd_udp), .cmd_end(cmd_end),
    .cmd_ready(cmd_ready), .rsp_data(rsp_data), .rsp_valid(rsp_valid),
    .rsp_last(rsp_last), .rsp_ready(rsp_ready));
`default_nettype wire
